// File: rtl/irx_biphase_tx.sv
// differential biphase bit encoder driving the load modulation switch
`timescale 1ns/100ps
`include "irx_defs.svh"
module irx_biphase_tx
#(
    parameter int HALF_CYC = `IRX_HALF_BIT_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bit_valid,
    input wire logic bit_value,
    output logic bit_ready,
    output logic mod_out
);
    logic busy, half, cur;
    logic next_busy, next_half, next_cur, next_mod;
    logic [15:0] cnt, next_cnt;
    logic end_half;

    if (HALF_CYC < 2 || HALF_CYC > 65535)
    begin : g_chk
        $error("half bit count out of range");
    end

    assign end_half = busy && (cnt == 16'(HALF_CYC - 1));
    // next bit is taken on the last cycle of the old one: no gap
    assign bit_ready = !busy || (half && end_half);

    always_comb
    begin
        next_busy = busy;
        next_half = half;
        next_cur = cur;
        next_mod = mod_out;
        next_cnt = cnt;
        if (busy)
        begin
            next_cnt = cnt + 16'h0001;
            if (end_half)
            begin
                next_cnt = 16'h0000;
                if (!half)
                begin
                    next_half = 1'b1;
                    if (cur)
                        next_mod = ~mod_out;
                end
                else
                    next_busy = 1'b0;
            end
        end
        if (bit_valid && bit_ready)
        begin
            next_busy = 1'b1;
            next_half = 1'b0;
            next_cnt = 16'h0000;
            next_cur = bit_value;
            next_mod = ~mod_out;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy <= 1'b0;
            half <= 1'b0;
            cur <= 1'b0;
            mod_out <= 1'b0;
            cnt <= 16'h0000;
        end
        else
        begin
            busy <= next_busy;
            half <= next_half;
            cur <= next_cur;
            mod_out <= next_mod;
            cnt <= next_cnt;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_start_edge;
        (bit_valid && bit_ready) |=> (mod_out != $past(mod_out));
    endproperty
    a_start_edge: assert property (p_start_edge)
        else $error("no transition at bit start");

    property p_mid_one;
        (!half && end_half && cur) |=> (mod_out != $past(mod_out));
    endproperty
    a_mid_one: assert property (p_mid_one)
        else $error("one bit lacks mid transition");

    property p_mid_zero;
        (!half && end_half && !cur) |=> $stable(mod_out);
    endproperty
    a_mid_zero: assert property (p_mid_zero)
        else $error("zero bit has mid transition");
endmodule

// File: rtl/irx_defs.svh
// offsets, field values, packet codes and timing counts of the rx link
`ifndef IRX_DEFS_SVH
`define IRX_DEFS_SVH
`define IRX_CLK_HZ 20000000
`define IRX_BIT_RATE_BPS 2000
`define IRX_HALF_BIT_CYC (`IRX_CLK_HZ / (2 * `IRX_BIT_RATE_BPS))
`define IRX_CE_FAST_MS 30
`define IRX_CE_SLOW_MS 250
`define IRX_CONV_MS 1000
`define IRX_MS_CYC(ms) ((ms) * (`IRX_CLK_HZ / 1000))
`define IRX_PREAMBLE_LAST 4'd10
`define IRX_BYTE_LAST 4'd10
`define IRX_HDR_SS 8'h01
`define IRX_HDR_EPT 8'h02
`define IRX_HDR_CE 8'h03
`define IRX_HDR_RP 8'h04
`define IRX_HDR_CFG 8'h51
`define IRX_HDR_ID 8'h71
`define IRX_EPT_UNKNOWN 8'h00
`define IRX_EPT_CHARGED 8'h01
`define IRX_EPT_NO_RESP 8'h08
`define IRX_VT_BAND0_MV 16'd7080
`define IRX_VT_BAND1_MV 16'd6280
`define IRX_VT_BAND2_MV 16'd5530
`define IRX_VT_BAND3_MV 16'd5110
`define IRX_VT_START_MV 16'd7200
`define IRX_TOL_MV 17'd40
`define IRX_CE_MAX 8'h7f
`define IRX_CE_MIN 8'h80
`define IRX_GAIN_RESET 16'd262
`define IRX_GAIN_SCALE 32'd1000
`define IRX_CFG_PAYLOAD 40'h0a00000100
`define IRX_RP_EVERY 2'd3
`define IRX_REG_CTRL 8'h00
`define IRX_REG_GAIN 8'h04
`define IRX_REG_STATUS 8'h08
`define IRX_REG_CE 8'h0c
`define IRX_CTRL_RESET 1'b1
`endif

// File: rtl/irx_link_ctrl.sv
// rx power link controller: start-up, main loop, packets, apb registers
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "irx_defs.svh"
module irx_link_ctrl
    import irx_pkg::*;
#(
    parameter int HALF_BIT_CYC = `IRX_HALF_BIT_CYC,
    parameter int CE_FAST_CYC = `IRX_MS_CYC(`IRX_CE_FAST_MS),
    parameter int CE_SLOW_CYC = `IRX_MS_CYC(`IRX_CE_SLOW_MS),
    parameter int CONV_CYC = `IRX_MS_CYC(`IRX_CONV_MS),
    // identification payload: value is arbitrary
    parameter logic [55:0] ID_PAYLOAD = 56'h10_5a5a_0000_0001
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic coil_power,
    input wire logic mode_select_a,
    input wire logic mode_select_b,
    input wire logic adapter_detect,
    input wire logic thermal_control_input,
    input wire logic [11:0] output_current_ma,
    input wire logic [15:0] rectifier_voltage,
    input wire logic [11:0] power_sense_input,
    input wire logic [15:0] limit_set_resistance,
    output logic mod_switch,
    output logic output_supply_en
);
    if (CE_FAST_CYC < 1 || CE_SLOW_CYC >= 2**25 || CONV_CYC >= 2**25 ||
        CE_FAST_CYC > CE_SLOW_CYC)
    begin : g_chk
        $error("timer counts out of range");
    end

    irx_pins_s pins_meta, pins;
    irx_state_e state, next_state;
    irx_kind_e kind, next_kind;
    irx_frame_e fstate, next_fstate;
    logic [24:0] timer, next_timer, conv, next_conv;
    logic [1:0] rpcnt, next_rpcnt, band, next_band;
    logic [15:0] target, next_target, band_mv, gain, next_gain;
    logic [7:0] ce_last, next_ce_last, rp_last, next_rp_last;
    logic [7:0] reason, next_reason, cur_byte, hdr, fchk, next_fchk;
    logic [7:0] ce_calc;
    logic out_en, next_out_en, ctrl_en, next_ctrl_en, launch, pkt_done;
    logic [3:0] fcnt, next_fcnt, fidx, next_fidx, plen, sel_idx;
    logic [10:0] fsr, next_fsr;
    logic [55:0] payload, shifted;
    logic [27:0] load_prod;
    logic [31:0] p5, p10, kq, next_prdata;
    logic signed [16:0] diff, q;
    logic [16:0] mag;
    logic at_target, shutdown, fidle, bit_ready, bit_take, bit_value;
    logic next_pready, next_pslverr;

    // pins come from outside the clock domain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pins_meta <= '0;
            pins <= '0;
        end
        else
        begin
            pins_meta <= {coil_power, mode_select_a, mode_select_b,
                          adapter_detect, thermal_control_input};
            pins <= pins_meta;
        end
    end

    // divide-free compare: i*r against fractions of the gain constant
    assign load_prod = output_current_ma * limit_set_resistance;
    assign p5 = {4'h0, load_prod} * 32'd5;
    assign p10 = {p5[30:0], 1'b0};
    assign kq = {16'h0000, gain} * `IRX_GAIN_SCALE;
    assign diff = $signed({1'b0, target}) - $signed({1'b0, rectifier_voltage});
    assign mag = diff[16] ? 17'(-diff) : 17'(diff);
    assign at_target = mag <= `IRX_TOL_MV;
    assign q = diff >>> 5;
    assign shutdown = pins.thermal | pins.sel_a |
                      (!pins.sel_b & pins.adapter);
    assign fidle = fstate == frm_idle;

    always_comb
    begin
        if (p10 < kq)
            next_band = 2'd0;
        else if (p5 < kq)
            next_band = 2'd1;
        else if (p5 < {kq[30:0], 1'b0})
            next_band = 2'd2;
        else
            next_band = 2'd3;
        case (band)
            2'd0: band_mv = `IRX_VT_BAND0_MV;
            2'd1: band_mv = `IRX_VT_BAND1_MV;
            2'd2: band_mv = `IRX_VT_BAND2_MV;
            default: band_mv = `IRX_VT_BAND3_MV;
        endcase
        if (at_target)
            ce_calc = 8'h00;
        else if (q > 17'sd127)
            ce_calc = `IRX_CE_MAX;
        else if (q < -17'sd128)
            ce_calc = `IRX_CE_MIN;
        else
            ce_calc = q[7:0];
    end

    // packet content per kind
    always_comb
    begin
        payload = 56'h0;
        case (kind)
            knd_ss:
            begin
                hdr = `IRX_HDR_SS;
                plen = 4'd1;
                payload[55:48] = rectifier_voltage[13:6];
            end
            knd_cfg:
            begin
                hdr = `IRX_HDR_CFG;
                plen = 4'd5;
                payload[55:16] = `IRX_CFG_PAYLOAD;
            end
            knd_id:
            begin
                hdr = `IRX_HDR_ID;
                plen = 4'd7;
                payload = ID_PAYLOAD;
            end
            knd_ce:
            begin
                hdr = `IRX_HDR_CE;
                plen = 4'd1;
                payload[55:48] = ce_last;
            end
            knd_rp:
            begin
                hdr = `IRX_HDR_RP;
                plen = 4'd1;
                payload[55:48] = rp_last;
            end
            default:
            begin
                hdr = `IRX_HDR_EPT;
                plen = 4'd1;
                payload[55:48] = reason;
            end
        endcase
        sel_idx = (fstate == frm_pre) ? 4'd0 : fidx + 4'd1;
        shifted = payload << {sel_idx - 4'd1, 3'b000};
        if (sel_idx == 4'd0)
            cur_byte = hdr;
        else if (sel_idx == plen + 4'd1)
            cur_byte = fchk;
        else
            cur_byte = shifted[55:48];
    end

    // control sequence; waits for an idle framer before each packet
    always_comb
    begin
        next_state = state;
        next_kind = kind;
        next_timer = timer;
        next_conv = conv;
        next_rpcnt = rpcnt;
        next_ce_last = ce_last;
        next_rp_last = rp_last;
        next_reason = reason;
        next_out_en = out_en;
        next_target = (state == irx_run) ? band_mv : `IRX_VT_START_MV;
        launch = 1'b0;
        case (state)
            irx_off:
                if (pins.power && ctrl_en)
                begin
                    if (shutdown)
                    begin
                        next_state = irx_ept;
                        next_reason = (pins.sel_a && pins.sel_b) ?
                            `IRX_EPT_CHARGED : `IRX_EPT_UNKNOWN;
                    end
                    else
                        next_state = irx_ss;
                end
            irx_ss, irx_cfg, irx_id, irx_start:
            begin
                if (fidle)
                begin
                    launch = 1'b1;
                    next_kind = (state == irx_ss) ? knd_ss :
                                (state == irx_cfg) ? knd_cfg :
                                (state == irx_id) ? knd_id : knd_ce;
                    next_ce_last = ce_calc;
                end
                if (pkt_done)
                begin
                    next_state = irx_state_e'(state + 3'd1);
                    next_out_en = state == irx_start;
                    next_timer = 25'd0;
                    next_conv = 25'd0;
                end
            end
            irx_run:
            begin
                next_conv = at_target ? 25'd0 : conv + 25'd1;
                if (timer != 25'd0)
                    next_timer = timer - 25'd1;
                if (fidle && (timer == 25'd0))
                begin
                    launch = 1'b1;
                    next_timer = at_target ? 25'(CE_SLOW_CYC - 1) :
                                             25'(CE_FAST_CYC - 1);
                    if (rpcnt == `IRX_RP_EVERY)
                    begin
                        next_kind = knd_rp;
                        next_rp_last = power_sense_input[11:4];
                        next_rpcnt = 2'd0;
                    end
                    else
                    begin
                        next_kind = knd_ce;
                        next_ce_last = ce_calc;
                        next_rpcnt = rpcnt + 2'd1;
                    end
                end
            end
            irx_ept:
                if (fidle)
                begin
                    launch = 1'b1;
                    next_kind = knd_ept;
                end
                else if (pkt_done)
                    next_state = irx_halt;
            default:
                next_state = irx_halt;
        endcase
        if (fidle && ((state == irx_ss) || (state == irx_cfg) ||
            (state == irx_id) || (state == irx_start) ||
            (state == irx_run)))
        begin
            if (shutdown)
            begin
                launch = 1'b0;
                next_state = irx_ept;
                next_out_en = 1'b0;
                next_reason = (pins.sel_a && pins.sel_b) ?
                    `IRX_EPT_CHARGED : `IRX_EPT_UNKNOWN;
            end
            else if (state == irx_run && conv >= 25'(CONV_CYC))
            begin
                launch = 1'b0;
                next_state = irx_ept;
                next_out_en = 1'b0;
                next_reason = `IRX_EPT_NO_RESP;
            end
        end
        if (!pins.power)
        begin
            launch = 1'b0;
            next_state = irx_off;
            next_out_en = 1'b0;
            next_rpcnt = 2'd0;
        end
    end

    // framer: 11 preamble ones, then start, 8 data lsb first, odd, stop
    assign bit_take = !fidle && bit_ready;
    assign bit_value = (fstate == frm_pre) ? 1'b1 : fsr[0];
    always_comb
    begin
        next_fstate = fstate;
        next_fcnt = fcnt;
        next_fidx = fidx;
        next_fsr = fsr;
        next_fchk = fchk;
        pkt_done = 1'b0;
        if (launch)
        begin
            next_fstate = frm_pre;
            next_fcnt = 4'd0;
            next_fidx = 4'd0;
            next_fchk = 8'h00;
        end
        else if (bit_take)
        begin
            next_fcnt = fcnt + 4'd1;
            next_fsr = {1'b0, fsr[10:1]};
            if (fcnt == `IRX_BYTE_LAST)
            begin
                next_fcnt = 4'd0;
                next_fsr = {1'b1, ~^cur_byte, cur_byte, 1'b0};
                next_fchk = fchk ^ cur_byte;
                next_fstate = frm_byte;
                if (fstate == frm_byte)
                    next_fidx = fidx + 4'd1;
                if (fstate == frm_byte && fidx == plen + 4'd1)
                begin
                    next_fstate = frm_idle;
                    pkt_done = 1'b1;
                end
            end
        end
    end

    irx_biphase_tx #(
        .HALF_CYC(HALF_BIT_CYC)
    ) u_bits (
        .pclk(pclk),
        .presetn(presetn),
        .bit_valid(!fidle),
        .bit_value(bit_value),
        .bit_ready(bit_ready),
        .mod_out(mod_switch)
    );

    // apb slave: one wait state, reads registered, writes on pready
    always_comb
    begin
        next_pready = psel && penable && !pready;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        next_ctrl_en = ctrl_en;
        next_gain = gain;
        if (next_pready)
        begin
            next_prdata = 32'h0;
            case (paddr)
                `IRX_REG_CTRL: next_prdata = {31'h0, ctrl_en};
                `IRX_REG_GAIN: next_prdata = {16'h0, gain};
                `IRX_REG_STATUS:
                    next_prdata = {16'h0, reason, 2'b00, band, out_en, state};
                `IRX_REG_CE: next_prdata = {target, 8'h00, ce_last};
                default: next_pslverr = 1'b1;
            endcase
        end
        if (psel && penable && pready && pwrite)
        begin
            if (paddr == `IRX_REG_CTRL)
                next_ctrl_en = pwdata[0];
            if (paddr == `IRX_REG_GAIN)
                next_gain = pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= irx_off;
            kind <= knd_ss;
            timer <= 25'd0;
            conv <= 25'd0;
            rpcnt <= 2'd0;
            band <= 2'd0;
            target <= `IRX_VT_START_MV;
            ce_last <= 8'h00;
            rp_last <= 8'h00;
            reason <= `IRX_EPT_UNKNOWN;
            out_en <= 1'b0;
            fstate <= frm_idle;
            fcnt <= 4'd0;
            fidx <= 4'd0;
            fsr <= 11'h7ff;
            fchk <= 8'h00;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ctrl_en <= `IRX_CTRL_RESET;
            gain <= `IRX_GAIN_RESET;
            output_supply_en <= 1'b0;
        end
        else
        begin
            state <= next_state;
            kind <= next_kind;
            timer <= next_timer;
            conv <= next_conv;
            rpcnt <= next_rpcnt;
            band <= next_band;
            target <= next_target;
            ce_last <= next_ce_last;
            rp_last <= next_rp_last;
            reason <= next_reason;
            out_en <= next_out_en;
            fstate <= pins.power ? next_fstate : frm_idle;
            fcnt <= next_fcnt;
            fidx <= next_fidx;
            fsr <= next_fsr;
            fchk <= next_fchk;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            ctrl_en <= next_ctrl_en;
            gain <= next_gain;
            output_supply_en <= next_out_en;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ce_sign;
        (launch && next_kind == knd_ce) |=> ($past(at_target) ?
            ce_last == 8'h00 : ce_last[7] == $past(diff[16]));
    endproperty
    a_ce_sign: assert property (p_ce_sign)
        else $error("control error sign wrong");

    property p_out_after_start;
        $rose(out_en) |-> $past(state) == irx_start && state == irx_run;
    endproperty
    a_out_after_start: assert property (p_out_after_start)
        else $error("output enabled before start-up request");

    property p_ce_contract;
        (launch && next_kind == knd_ce) |-> state inside {irx_start, irx_run};
    endproperty
    a_ce_contract: assert property (p_ce_contract)
        else $error("control packet before contract");

    property p_cfg_order;
        (state == irx_cfg && $past(state) != irx_cfg) |->
            $past(state) == irx_ss;
    endproperty
    a_cfg_order: assert property (p_cfg_order)
        else $error("configuration not after signal strength");

    property p_band0;
        (state == irx_run && band == 2'd0 && pins.power) |=>
            (state != irx_run || target == 16'd7080);
    endproperty
    a_band0: assert property (p_band0)
        else $error("band zero target wrong");

    property p_band3;
        (state == irx_run && band == 2'd3 && pins.power) |=>
            (state != irx_run || target == 16'd5110);
    endproperty
    a_band3: assert property (p_band3)
        else $error("top band target wrong");

    property p_charged;
        (state == irx_off && pins.power && ctrl_en && pins.sel_a &&
         pins.sel_b) |=> (state == irx_ept && reason == 8'h01);
    endproperty
    a_charged: assert property (p_charged)
        else $error("charge complete reason missing");

    property p_ept_header;
        (launch && next_kind == knd_ept) |=> hdr == 8'h02 ##1 kind == knd_ept;
    endproperty
    a_ept_header: assert property (p_ept_header)
        else $error("end packet header wrong");

    property p_fast_rate;
        (state == irx_run && launch && !at_target && pins.power) |=>
            timer == 25'(CE_FAST_CYC - 1);
    endproperty
    a_fast_rate: assert property (p_fast_rate)
        else $error("fast error interval wrong");
endmodule

// File: rtl/irx_pkg.sv
// types shared by the rx link controller
package irx_pkg;
    typedef enum logic [2:0] {
        irx_off, irx_ss, irx_cfg, irx_id, irx_start, irx_run, irx_ept,
        irx_halt
    } irx_state_e;
    typedef enum logic [1:0] {frm_idle, frm_pre, frm_byte} irx_frame_e;
    typedef enum logic [2:0] {
        knd_ss, knd_cfg, knd_id, knd_ce, knd_rp, knd_ept
    } irx_kind_e;
    typedef struct packed {
        logic power;
        logic sel_a;
        logic sel_b;
        logic adapter;
        logic thermal;
    } irx_pins_s;
endpackage

// File: verification/irx_link_ctrl_tb_top.sv
// bench for the rx link controller: apb, start-up, bands, shutdown
`timescale 1ns/100ps
module irx_link_ctrl_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic coil_power = 0, mode_select_a = 0, mode_select_b = 0;
    logic adapter_detect = 0, thermal_control_input = 0, err;
    logic pready, pslverr, mod_switch, output_supply_en;
    logic [7:0] paddr = 0, hdr, pay, npkt;
    logic [3:0] nb;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [11:0] output_current_ma = 12'h063, power_sense_input = 12'h5a0;
    logic [15:0] rectifier_voltage = 16'h1c20;
    logic [15:0] limit_set_resistance = 16'h0106;
    int errors = 0, check_count = 0;
    irx_link_ctrl #(.HALF_BIT_CYC(4), .CE_FAST_CYC(400),
        .CE_SLOW_CYC(2000), .CONV_CYC(8000)) i_irx_link_ctrl
    (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .coil_power, .mode_select_a,
        .mode_select_b, .adapter_detect, .thermal_control_input,
        .output_current_ma, .rectifier_voltage, .power_sense_input,
        .limit_set_resistance, .mod_switch, .output_supply_en
    );
    irx_pad_model i_irx_pad_model
    (
        .pclk, .mod_switch, .hdr, .pay, .npkt, .nb
    );
    initial
        forever
            #25 pclk = ~pclk;
    task automatic finish_test();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tmo();
        errors++;
        $display("MISMATCH %0t wait ran out", $time);
        finish_test();
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 9; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 9)
            tmo();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // waits until a new packet has shown its header and first payload byte
    task automatic wpk();
        logic [7:0] n;
        int i;
        n = npkt;
        for (i = 0; i < 9000; i++)
        begin
            @(posedge pclk);
            if (npkt != n && nb >= 4'h2)
                break;
        end
        if (i == 9000)
            tmo();
    endtask
    task automatic s_regs();
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[15:0], 16'h0106);
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[14:0], err}, 16'h0001);
        chk({15'h0, mod_switch}, 16'h0000);
    endtask
    task automatic s_start();
        int i;
        logic [7:0] h [4] = '{8'h01, 8'h51, 8'h71, 8'h03};
        coil_power <= 1'b1; // ping powers the receiver
        for (i = 0; i < 4; i++)
        begin
            wpk();
            chk({8'h0, hdr}, {8'h0, h[i]});
            chk({15'h0, output_supply_en}, 16'h0000);
        end
        wpk();
        chk({15'h0, output_supply_en}, 16'h0001);
    endtask
    task automatic s_band();
        int i;
        logic [11:0] c [5] = '{12'h063, 12'h064, 12'h0c8, 12'h190, 12'h190};
        logic [15:0] t [5] = '{16'h1ba8, 16'h1888, 16'h159a, 16'h13f6,
            16'h159a};
        for (i = 0; i < 5; i++)
        begin
            if (i == 4)
                apb(1'b1, 8'h04, 32'h0000020c); // gain doubled
            output_current_ma <= c[i];
            rectifier_voltage <= t[i];
            repeat (8) @(posedge pclk);
            apb(1'b0, 8'h0c, 32'h0);
            chk(rd[31:16], t[i]);
        end
    endtask
    task automatic s_sign();
        int i;
        logic [15:0] v [2] = '{16'h11b2, 16'h1982};
        logic [7:0] e [2] = '{8'h1f, 8'he0};
        for (i = 0; i < 2; i++)
        begin
            rectifier_voltage <= v[i];
            repeat (3) wpk();
            apb(1'b0, 8'h0c, 32'h0);
            chk({8'h0, rd[7:0]}, {8'h0, e[i]});
        end
    endtask
    task automatic s_conv();
        int i;
        for (i = 0; i < 30 && hdr !== 8'h02; i++)
        begin
            wpk();
            if (hdr === 8'h04)
                chk({8'h0, pay}, 16'h005a);
        end
        chk({hdr, pay}, 16'h0208);
        chk({15'h0, output_supply_en}, 16'h0000);
    endtask
    task automatic s_shut();
        int i;
        logic [3:0] p [4] = '{4'h1, 4'h8, 4'h2, 4'hc};
        for (i = 0; i < 4; i++)
        begin
            coil_power <= 1'b0;
            repeat (40) @(posedge pclk);
            {mode_select_a, mode_select_b, adapter_detect,
                thermal_control_input} <= p[i];
            coil_power <= 1'b1;
            wpk();
            chk({hdr, pay}, {15'h0100, p[i] == 4'hc});
        end
    endtask
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_start();
        s_band();
        s_sign();
        s_conv();
        s_shut();
        finish_test();
    end
endmodule

// File: verification/irx_pad_model.sv
// pad side model: decodes load modulation packets from the switch line
`timescale 1ns/100ps
module irx_pad_model
(
    input wire logic pclk,
    input wire logic mod_switch,
    output logic [7:0] hdr,
    output logic [7:0] pay,
    output logic [7:0] npkt,
    output logic [3:0] nb
);
    logic prev = 0, half = 0, inb = 0;
    logic [7:0] sr = 0;
    logic [3:0] cnt = 0, k = 0;
    int gap = 0;
    int ones = 0;
    initial
        {hdr, pay, npkt, nb} = '0;
    task automatic take(input logic b);
        ones = b ? ones + 1 : 0;
        // packets may abut with no idle gap: only a preamble has 11 ones
        if (ones >= 11)
        begin
            k = 0;
            inb = 0;
        end
        else if (!inb)
        begin
            inb = !b;
            cnt = 0;
        end
        else if (++cnt == 10)
        begin
            inb = 0;
            k++;
            nb <= k;
            if (k == 1)
                npkt <= npkt + 8'h01;
            if (k == 1)
                hdr <= sr;
            if (k == 2)
                pay <= sr;
        end
        else if (cnt < 9)
            sr = {b, sr[7:1]};
    endtask
    // listens only, no way back to the receiver
    always @(posedge pclk)
    begin
        gap++;
        if (mod_switch !== prev)
        begin
            if (gap > 12)
            begin
                k = 0;
                inb = 0;
            end
            else if (gap > 6)
                take(1'b0); // full cell without mid edge
            else if (half)
                take(1'b1); // two half cells
            half = gap <= 6 && !half;
            gap = 0;
        end
        prev = mod_switch;
    end
endmodule
